/* hdl/dag_defines.vh */
`ifndef DAG_DEFINES_VH
`define DAG_DEFINES_VH
// Widths
`define DAG_IDX_W      16
`define DAG_PAGE_W     8
`define DAG_ADDR_W     24
`define DAG_OFS_W      8
// Reset values
`define DAG_IDX_RST    16'h0000
`define DAG_PAGE_RST   8'h00
`define DAG_ADDR_RST   24'h000000
`define DAG_BANK_RST   1'h0
// Operation codes
`define DAG_OP_POSTMOD 2'h0
`define DAG_OP_PREMOD  2'h1
`define DAG_OP_PREOFS  2'h2
`define DAG_OP_POSTOFS 2'h3
// Register-load select codes
`define DAG_LD_INDEX   2'h0
`define DAG_LD_MODIFY  2'h1
`define DAG_LD_LENGTH  2'h2
`define DAG_LD_BASE    2'h3
`endif

/* hdl/dag_unit.v */
`timescale 1ns/100ps
`include "dag_defines.vh"
// Register store of one address generator: primary and secondary banks
module dag_unit
(
  input  wire        clk_i,     // Core clock
  input  wire        resetn_i,  // Async reset, active low
  input  wire        bank_i,    // Active bank select (0 primary)
  input  wire [1:0]  ptr_i,     // Index pointer select
  input  wire [1:0]  mod_i,     // Modify register select
  input  wire        upd_i,     // Write back the updated pointer
  input  wire [15:0] upd_val_i, // Updated pointer value
  input  wire        ld_i,      // Register load strobe
  input  wire [1:0]  ld_kind_i, // Register kind to load
  input  wire [1:0]  ld_sel_i,  // Register number to load
  input  wire [15:0] ld_val_i,  // Value to load
  input  wire        pg_ld_i,   // Page register load
  input  wire [7:0]  pg_val_i,  // Page value
  output wire [15:0] idx_o,     // Selected index pointer
  output wire [15:0] mdf_o,     // Selected modify value
  output wire [15:0] len_o,     // Length of selected pointer
  output wire [15:0] bas_o,     // Base of selected pointer
  output wire [7:0]  page_o     // Page register
);

  // Bank bit sits on top so the two sets never alias
  reg  [15:0] idx  [0:7];  // Index pointers
  reg  [15:0] mdf  [0:7];  // Modify values
  reg  [15:0] len  [0:7];  // Buffer lengths
  reg  [15:0] bas  [0:7];  // Buffer bases
  reg  [7:0]  page;        // Page, shared by both banks
  integer     i;
  wire [2:0]  sel  = {bank_i, ptr_i};
  wire [2:0]  msel = {bank_i, mod_i};
  wire [2:0]  lsel = {bank_i, ld_sel_i};

  //////////////////////////////////////////////////////////////////
  // Read ports are plain muxes; the caller registers what leaves
  assign idx_o  = idx[sel];
  assign mdf_o  = mdf[msel];
  assign len_o  = len[sel];
  assign bas_o  = bas[sel];
  assign page_o = page;

  //////////////////////////////////////////////////////////////////
  // Register store; a load lands after the write-back, so it wins
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        idx[i] <= `DAG_IDX_RST;
        mdf[i] <= `DAG_IDX_RST;
        len[i] <= `DAG_IDX_RST;
        bas[i] <= `DAG_IDX_RST;
      end
      page <= `DAG_PAGE_RST;
    end
    else
    begin
      if (upd_i)
        idx[sel] <= upd_val_i;
      if (ld_i)
      begin
        case (ld_kind_i)
          `DAG_LD_INDEX  : idx[lsel] <= ld_val_i;
          `DAG_LD_MODIFY : mdf[lsel] <= ld_val_i;
          `DAG_LD_LENGTH : len[lsel] <= ld_val_i;
          default        : bas[lsel] <= ld_val_i;
        endcase
      end
      if (pg_ld_i)
        page <= pg_val_i;
    end
  end

endmodule

/* hdl/dag_top.v */
// How it works
// - Each generator holds four 16-bit index pointers, updated on accesses.
// - Both generators yield an address in the same cycle.
// - Indirect access modifies pointer pre or post by one of four modify registers.
// - Signed 8-bit immediate offset before or after; pre-offset leaves pointer.
// - Length and base define a circular buffer the pointer stays within.
// - Circular wrap stays inside the 64K page; never crosses page boundary.
// - Secondary copy of all registers but the shared page; bank switch takes one cycle.
// - Index forms low 16 bits; own 8-bit page register gives upper eight.
`timescale 1ns/100ps
`include "dag_defines.vh"
module dag_top
(
  input  wire        clk_i,       // Core clock 25 MHz
  input  wire        resetn_i,    // Async reset, active low
  input  wire        bank_sw_i,   // Context switch request pulse
  input  wire        dm_req_i,    // Data memory access request
  input  wire [1:0]  dm_op_i,     // Data side operation
  input  wire [1:0]  dm_ptr_i,    // Data side pointer select
  input  wire [1:0]  dm_mod_i,    // Data side modify select
  input  wire [7:0]  dm_ofs_i,    // Data side offset
  input  wire        pm_req_i,    // Program memory access request
  input  wire [1:0]  pm_op_i,     // Program side operation
  input  wire [1:0]  pm_ptr_i,    // Program side pointer select
  input  wire [1:0]  pm_mod_i,    // Program side modify select
  input  wire [7:0]  pm_ofs_i,    // Program side offset
  input  wire        ld_i,        // Register load strobe
  input  wire        ld_gen_i,    // Generator to load (0 data)
  input  wire [1:0]  ld_kind_i,   // Register kind
  input  wire [1:0]  ld_sel_i,    // Register number
  input  wire [15:0] ld_val_i,    // Load value
  input  wire        pg_ld_i,     // Page load strobe
  input  wire        pg_gen_i,    // Generator of page load
  input  wire [7:0]  pg_val_i,    // Page value
  output reg         bank_o,      // Active bank
  output reg  [23:0] dm_addr_o,   // Data memory address
  output reg         dm_valid_o,  // Data address valid
  output reg  [23:0] pm_addr_o,   // Program memory address
  output reg         pm_valid_o   // Program address valid
);

  // Per-generator views of the two register stores; each side
  // sees only its own pointers, so the two can never collide
  wire [15:0] dm_idx;       // Data side selected pointer
  wire [15:0] dm_mdf;       // Data side selected modify value
  wire [15:0] dm_len;       // Data side buffer length
  wire [15:0] dm_bas;       // Data side buffer base
  wire [7:0]  dm_page;      // Data side page
  wire [15:0] pm_idx;       // Program side selected pointer
  wire [15:0] pm_mdf;       // Program side selected modify value
  wire [15:0] pm_len;       // Program side buffer length
  wire [15:0] pm_bas;       // Program side buffer base
  wire [7:0]  pm_page;      // Program side page
  wire [15:0] dm_eff;       // Data side index on the bus
  wire [15:0] pm_eff;       // Program side index on the bus
  wire [15:0] next_dm_idx;  // Data side written-back pointer
  wire [15:0] next_pm_idx;  // Program side written-back pointer
  wire        dm_ld;        // Register load steered to data side
  wire        pm_ld;        // Register load steered to program side
  wire        dm_pg_ld;     // Page load steered to data side
  wire        pm_pg_ld;     // Page load steered to program side

  //////////////////////////////////////////////////////////////////
  // Circular wrap of a pointer moved by a signed step. The sum is
  // cut to 16 bits, so a buffer can never leak into the page bits;
  // a length of zero turns the wrap off for linear pointers.
  function [15:0] wrap;
    input [15:0] ptr;
    input [16:0] step;
    input [15:0] len;
    input [15:0] bas;
    reg   [16:0] sum;
    reg   [16:0] top;
    begin
      sum = {1'h0, ptr} + step;
      top = {1'h0, bas} + {1'h0, len};
      if (len == 16'h0000)
        wrap = sum[15:0];
      else if (!step[16] && sum[15:0] >= top[15:0])
        wrap = sum[15:0] - len;
      else if (step[16] && sum[15:0] < bas)
        wrap = sum[15:0] + len;
      else
        wrap = sum[15:0];
    end
  endfunction

  // Index that goes out with the access; only the pre forms move it
  function [15:0] eff_idx;
    input [1:0]  op;
    input [15:0] cur;
    input [15:0] mval;
    input [7:0]  ofs;
    input [15:0] len;
    input [15:0] bas;
    begin
      case (op)
        `DAG_OP_PREMOD : eff_idx = wrap(cur, {mval[15], mval}, len, bas);
        `DAG_OP_PREOFS : eff_idx = wrap(cur, {{9{ofs[7]}}, ofs}, len, bas);
        default        : eff_idx = cur;
      endcase
    end
  endfunction

  // Pointer written back after the access; pre-offset leaves it alone
  function [15:0] next_ptr;
    input [1:0]  op;
    input [15:0] cur;
    input [15:0] mval;
    input [7:0]  ofs;
    input [15:0] len;
    input [15:0] bas;
    begin
      case (op)
        `DAG_OP_POSTMOD : next_ptr = wrap(cur, {mval[15], mval}, len, bas);
        `DAG_OP_PREMOD  : next_ptr = wrap(cur, {mval[15], mval}, len, bas);
        `DAG_OP_POSTOFS : next_ptr = wrap(cur, {{9{ofs[7]}}, ofs}, len, bas);
        default         : next_ptr = cur;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////
  // Both generators compute in parallel from their own stores
  assign dm_eff      = eff_idx(dm_op_i, dm_idx, dm_mdf, dm_ofs_i, dm_len, dm_bas);
  assign pm_eff      = eff_idx(pm_op_i, pm_idx, pm_mdf, pm_ofs_i, pm_len, pm_bas);
  assign next_dm_idx = next_ptr(dm_op_i, dm_idx, dm_mdf, dm_ofs_i, dm_len, dm_bas);
  assign next_pm_idx = next_ptr(pm_op_i, pm_idx, pm_mdf, pm_ofs_i, pm_len, pm_bas);

  // One shared load bus, steered by the generator bit; a user who
  // loads and accesses the same pointer in one cycle gets the load
  assign dm_ld       = ld_i & ~ld_gen_i;
  assign pm_ld       = ld_i & ld_gen_i;
  assign dm_pg_ld    = pg_ld_i & ~pg_gen_i;
  assign pm_pg_ld    = pg_ld_i & pg_gen_i;

  //////////////////////////////////////////////////////////////////
  // Bank select toggles in one cycle; both generators follow it
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      bank_o <= `DAG_BANK_RST;
    else if (bank_sw_i)
      bank_o <= ~bank_o;
  end

  //////////////////////////////////////////////////////////////////
  // Bus outputs straight from flops; the address holds between
  // requests so a slow memory may keep sampling it
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dm_addr_o  <= `DAG_ADDR_RST;
      dm_valid_o <= 1'h0;
      pm_addr_o  <= `DAG_ADDR_RST;
      pm_valid_o <= 1'h0;
    end
    else
    begin
      dm_valid_o <= dm_req_i;
      pm_valid_o <= pm_req_i;
      if (dm_req_i)
        dm_addr_o <= {dm_page, dm_eff};
      if (pm_req_i)
        pm_addr_o <= {pm_page, pm_eff};
    end
  end

  //////////////////////////////////////////////////////////////////
  // Data side register store
  dag_unit u_data_addr_gen
  (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .bank_i    (bank_o),
    .ptr_i     (dm_ptr_i),
    .mod_i     (dm_mod_i),
    .upd_i     (dm_req_i),
    .upd_val_i (next_dm_idx),
    .ld_i      (dm_ld),
    .ld_kind_i (ld_kind_i),
    .ld_sel_i  (ld_sel_i),
    .ld_val_i  (ld_val_i),
    .pg_ld_i   (dm_pg_ld),
    .pg_val_i  (pg_val_i),
    .idx_o     (dm_idx),
    .mdf_o     (dm_mdf),
    .len_o     (dm_len),
    .bas_o     (dm_bas),
    .page_o    (dm_page)
  );

  //////////////////////////////////////////////////////////////////
  // Program side register store
  dag_unit u_prog_addr_gen
  (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .bank_i    (bank_o),
    .ptr_i     (pm_ptr_i),
    .mod_i     (pm_mod_i),
    .upd_i     (pm_req_i),
    .upd_val_i (next_pm_idx),
    .ld_i      (pm_ld),
    .ld_kind_i (ld_kind_i),
    .ld_sel_i  (ld_sel_i),
    .ld_val_i  (ld_val_i),
    .pg_ld_i   (pm_pg_ld),
    .pg_val_i  (pg_val_i),
    .idx_o     (pm_idx),
    .mdf_o     (pm_mdf),
    .len_o     (pm_len),
    .bas_o     (pm_bas),
    .page_o    (pm_page)
  );

endmodule

/* dv/dag_checker.sv */
`timescale 1ns/100ps
//////////////////////////////////////////////////
// Port-level timing checks on the generator pair
module dag_checker
(
  input wire        clk_i,      // Clock
  input wire        resetn_i,   // Reset
  input wire        bank_sw_i,  // Bank switch
  input wire        dm_req_i,   // Data request
  input wire        pm_req_i,   // Program request
  input wire        pg_ld_i,    // Page load
  input wire        pg_gen_i,   // Page target
  input wire [7:0]  pg_val_i,   // Page value
  input wire        bank_o,     // Bank
  input wire [23:0] dm_addr_o,  // Data address
  input wire        dm_valid_o, // Data valid
  input wire        pm_valid_o  // Program valid
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  dm_answer_a: assert property (dm_req_i |=> dm_valid_o) else $error("data valid missing");
  dm_quiet_a: assert property (!dm_req_i |=> !dm_valid_o) else $error("data valid unasked");
  pm_quiet_a: assert property (!pm_req_i |=> !pm_valid_o) else $error("program valid unasked");
  dual_issue_a: assert property (dm_req_i && pm_req_i |=> dm_valid_o && pm_valid_o)
    else $error("dual issue not same cycle");
  bank_flip_a: assert property (bank_sw_i |=> bank_o != $past(bank_o)) else $error("bank not switched");
  bank_hold_a: assert property (!bank_sw_i |=> $stable(bank_o)) else $error("bank moved");
  addr_hold_a: assert property (!dm_req_i |=> $stable(dm_addr_o)) else $error("address moved");
  page_bits_a: assert property (pg_ld_i && !pg_gen_i ##1 !pg_ld_i ##1 (dm_req_i && !pg_ld_i)
    |=> dm_addr_o[23:16] == $past(pg_val_i, 3)) else $error("page bits wrong");
endmodule
bind dag_top dag_checker chk (.clk_i(clk_i), .resetn_i(resetn_i), .bank_sw_i(bank_sw_i), .dm_req_i(dm_req_i),
  .pm_req_i(pm_req_i), .pg_ld_i(pg_ld_i), .pg_gen_i(pg_gen_i), .pg_val_i(pg_val_i), .bank_o(bank_o),
  .dm_addr_o(dm_addr_o), .dm_valid_o(dm_valid_o), .pm_valid_o(pm_valid_o));

/* dv/dag_bus_model.sv */
`timescale 1ns/100ps
//////////////////////////////////////////////////
// Memory bus side: counts every operand fetch
module dag_bus_model
(
  input  wire       clk_i,      // Clock
  input  wire       resetn_i,   // Reset, active low
  input  wire       dm_valid_i, // Data fetch
  input  wire       pm_valid_i, // Program fetch
  output reg  [7:0] fetch_o     // Fetch count
);
  // Both buses may fetch in one cycle; reset keeps an early unknown out of the count
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      fetch_o <= 8'h00;
    else
      fetch_o <= fetch_o + dm_valid_i + pm_valid_i;
endmodule

/* dv/tb_dual_data_address_generator.sv */
`timescale 1ns/100ps
module tb_dual_data_address_generator;
  logic clk = 0, resetn = 0, bsw = 0, dq = 0, pq = 0, ld = 0, lg = 0, pl = 0, pgn = 0;
  logic [1:0] op = 0, pt = 0, md = 0, lk = 0, ls = 0;
  logic [7:0] of = 0, pgv = 0;
  logic [15:0] lv = 0;
  wire [23:0] da, pa;
  wire [7:0] nf;
  wire bk, dv, pv;
  int fail_count = 0, checked = 0;
  dag_top uut (.clk_i(clk), .resetn_i(resetn), .bank_sw_i(bsw), .dm_req_i(dq), .dm_op_i(op), .dm_ptr_i(pt),
    .dm_mod_i(md), .dm_ofs_i(of), .pm_req_i(pq), .pm_op_i(op), .pm_ptr_i(pt), .pm_mod_i(md), .pm_ofs_i(of),
    .ld_i(ld), .ld_gen_i(lg), .ld_kind_i(lk), .ld_sel_i(ls), .ld_val_i(lv), .pg_ld_i(pl), .pg_gen_i(pgn),
    .pg_val_i(pgv), .bank_o(bk), .dm_addr_o(da), .dm_valid_o(dv), .pm_addr_o(pa), .pm_valid_o(pv));
  dag_bus_model mem (.clk_i(clk), .resetn_i(resetn), .dm_valid_i(dv), .pm_valid_i(pv), .fetch_o(nf));
  // Clock
  always #20 clk = ~clk;
  //////////////////////////////////////////////////
  task chk(string n, logic [23:0] e, g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task ld_reg(logic g, logic [1:0] k, s, logic [15:0] v);
    @(negedge clk); lg = g; lk = k; ls = s; lv = v; ld = 1;
    @(negedge clk); ld = 0;
  endtask
  task ld_page(logic g, logic [7:0] v);
    @(negedge clk); pgn = g; pgv = v; pl = 1;
    @(negedge clk); pl = 0;
  endtask
  // Valid is looked at in its one cycle
  task acc(logic d, p, logic [1:0] o, t, m, logic [7:0] f, logic [23:0] ed, ep);
    @(negedge clk); dq = d; pq = p; op = o; pt = t; md = m; of = f;
    @(negedge clk); dq = 0; pq = 0;
    if (d) chk("dm_addr", ed, dv === 1'b1 ? da : ~ed);
    if (p) chk("pm_addr", ep, pv === 1'b1 ? pa : ~ep);
  endtask
  task switch_bank(logic [23:0] e);
    @(negedge clk); bsw = 1;
    @(negedge clk); bsw = 0;
    chk("bank", e, {23'h0, bk});
  endtask
  //////////////////////////////////////////////////
  task t_modes;
    ld_page(0, 8'h12);
    ld_reg(0, 0, 0, 16'h0010); ld_reg(0, 1, 0, 16'h0003); ld_reg(0, 0, 1, 16'h0020);
    ld_reg(0, 1, 1, 16'hfffe); ld_reg(0, 0, 2, 16'h0040); ld_reg(0, 0, 3, 16'h0050);
    acc(1, 0, 0, 0, 0, 0, 24'h120010, 0); acc(1, 0, 0, 0, 0, 0, 24'h120013, 0);
    acc(1, 0, 1, 1, 1, 0, 24'h12001e, 0); acc(1, 0, 1, 1, 1, 0, 24'h12001c, 0);
    acc(1, 0, 2, 2, 0, 8'h80, 24'h12ffc0, 0); acc(1, 0, 2, 2, 0, 8'h80, 24'h12ffc0, 0);
    acc(1, 0, 3, 3, 0, 8'h7f, 24'h120050, 0); acc(1, 0, 3, 3, 0, 8'h7f, 24'h1200cf, 0);
  endtask
  // Ring of four words at 0x100 on the program side
  task t_circ;
    ld_page(1, 8'h34); ld_reg(1, 0, 0, 16'h0100); ld_reg(1, 3, 0, 16'h0100); ld_reg(1, 2, 0, 16'h0004);
    ld_reg(1, 1, 2, 16'h0003); ld_reg(1, 1, 3, 16'hfffd);
    acc(0, 1, 0, 0, 2, 0, 0, 24'h340100); acc(0, 1, 0, 0, 2, 0, 0, 24'h340103);
    acc(0, 1, 0, 0, 3, 0, 0, 24'h340102); acc(0, 1, 0, 0, 3, 0, 0, 24'h340103);
  endtask
  task t_dual;
    acc(1, 1, 2, 0, 0, 0, 24'h120016, 24'h340100);
    ld_page(0, 8'hff);
    acc(1, 1, 2, 0, 0, 0, 24'hff0016, 24'h340100);
  endtask
  // Secondary set starts clear; page is shared
  task t_bank;
    switch_bank(24'h1);
    acc(1, 0, 0, 0, 0, 0, 24'hff0000, 0);
    ld_reg(0, 0, 0, 16'h0abc);
    acc(1, 0, 2, 0, 0, 0, 24'hff0abc, 0);
    switch_bank(24'h0);
    acc(1, 0, 2, 0, 0, 0, 24'hff0016, 0);
  endtask
  // The count takes the last valid one edge later
  task t_count;
    @(negedge clk);
    chk("fetches", 24'h13, {16'h0, nf});
  endtask
  //////////////////////////////////////////////////
  task end_of_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    resetn = 1;
    t_modes; t_circ; t_dual; t_bank; t_count;
    end_of_test;
  end
  // Run needs about 80 cycles
  initial
  begin
    #40000;
    fail_count++;
    end_of_test;
  end
endmodule
